// ### hw/ira_top.sv
// Indirect register access block with Wishbone slave and link detect timer.
//
// Notes on behaviour
// - Two-bit field picks link timeout: 325us, 162us, 650us or 1.3ms.
// - Link detect drops when timeout passes without valid reverse traffic.
// - Analog select: 000 off, 100 video receiver, 101 serial transmitter.
// - With autostep set, analog offset steps by one after each access.
// - Analog read control 0 makes accesses writes, 1 makes them reads.
// - Eight-bit analog offset register, reset zero, addresses each access.
// - Writing analog data forwards the byte to the selected target.
// - Reading analog data returns the selected target register contents.
// - Peripheral select: 10 configuration data, 11 die identity.
// - With autostep set, peripheral address grows by one per access.
// - Writing 1 to read start launches a peripheral read.
// - Peripheral read data lands in the low data byte register.
// - Read start clears itself when the peripheral read completes.
// - Peripheral accesses only while enabled, routed by target select.
// - Peripheral address low byte: eight-bit read/write, reset zero.
// - Peripheral data low byte: eight-bit read/write, reset zero.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps

module ira_top #(
  parameter int unsigned LD_CYC_00 =
    ira_pkg::LD_TO_00_US * ira_pkg::NS_PER_US / ira_pkg::CLK_PERIOD_NS,
  parameter int unsigned LD_CYC_01 =
    ira_pkg::LD_TO_01_US * ira_pkg::NS_PER_US / ira_pkg::CLK_PERIOD_NS,
  parameter int unsigned LD_CYC_10 =
    ira_pkg::LD_TO_10_US * ira_pkg::NS_PER_US / ira_pkg::CLK_PERIOD_NS,
  parameter int unsigned LD_CYC_11 =
    ira_pkg::LD_TO_11_US * ira_pkg::NS_PER_US / ira_pkg::CLK_PERIOD_NS
) (
  input  wire logic        SYS_CLK_I,     // System clock, 10 MHz.
  input  wire logic        RST_N_I,       // Asynchronous reset, active low.
  input  wire logic        WB_CYC_I,      // Wishbone cycle.
  input  wire logic        WB_STB_I,      // Wishbone strobe.
  input  wire logic        WB_WE_I,       // Wishbone write enable.
  input  wire logic [8:0]  WB_ADR_I,      // Wishbone byte address.
  input  wire logic [3:0]  WB_SEL_I,      // Wishbone byte selects.
  input  wire logic [31:0] WB_DAT_I,      // Wishbone write data.
  output logic      [31:0] WB_DAT_O,      // Wishbone read data.
  output logic             WB_ACK_O,      // Wishbone acknowledge.
  input  wire logic        RC_VALID_I,    // Valid reverse channel traffic.
  output logic             LINK_DETECT_O, // Reverse link detected.
  output logic      [2:0]  ANA_SEL_O,     // Analog target select.
  output logic      [7:0]  ANA_ADDR_O,    // Analog register offset.
  output logic      [7:0]  ANA_WDATA_O,   // Analog write data.
  output logic             ANA_WE_O,      // Analog write strobe.
  output logic             ANA_RE_O,      // Analog read strobe.
  input  wire logic [7:0]  ANA_RDATA_I,   // Analog read data.
  output logic             PB_REQ_O,      // Peripheral read request.
  output logic      [1:0]  PB_SEL_O,      // Peripheral target select.
  output logic      [7:0]  PB_ADDR_O,     // Peripheral address.
  input  wire logic [7:0]  PB_RDATA_I,    // Peripheral read data.
  input  wire logic        PB_ACK_I       // Peripheral read done.
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------
  function automatic logic [7:0] incr8(input logic [7:0] v);
    incr8 = 8'(v + ira_pkg::STEP8);
  endfunction : incr8

  function automatic logic ana_target_ok(input logic [2:0] s);
    ana_target_ok = (s == ira_pkg::ANA_SEL_VRX) ||
                    (s == ira_pkg::ANA_SEL_STX);
  endfunction : ana_target_ok

  function automatic logic [ira_pkg::LD_CNT_W-1:0] ld_limit(
    input logic [1:0] t
  );
    case (t)
      2'h0:    ld_limit = ira_pkg::LD_CNT_W'(LD_CYC_00);
      2'h1:    ld_limit = ira_pkg::LD_CNT_W'(LD_CYC_01);
      2'h2:    ld_limit = ira_pkg::LD_CNT_W'(LD_CYC_10);
      default: ld_limit = ira_pkg::LD_CNT_W'(LD_CYC_11);
    endcase
  endfunction : ld_limit

  // Reserved bits are built in as zero here, so reads never expose them.
  function automatic logic [31:0] rd_mux(
    input ira_pkg::ira_state_t s,
    input logic [6:0]          idx
  );
    logic [7:0] b;
    b = ira_pkg::RST_BYTE;
    case (idx)
      ira_pkg::REG_LINK_DET:
        b[ira_pkg::LD_TIMER_LSB +: 2] = s.ld_timer;
      ira_pkg::REG_ANA_CTRL:
      begin
        b[ira_pkg::ANA_SEL_LSB +: 3] = s.ana_sel;
        b[ira_pkg::ANA_INC_BIT]      = s.ana_inc;
        b[ira_pkg::ANA_RD_BIT]       = s.ana_rd;
      end
      ira_pkg::REG_ANA_OFF:  b = s.ana_off;
      ira_pkg::REG_ANA_DATA: b = s.ana_data;
      ira_pkg::REG_PB_CTRL:
      begin
        b[ira_pkg::PB_SEL_LSB +: 2] = s.pb_sel;
        b[ira_pkg::PB_INC_BIT]      = s.pb_inc;
        b[ira_pkg::PB_START_BIT]    = s.pb_start;
        b[ira_pkg::PB_EN_BIT]       = s.pb_en;
      end
      ira_pkg::REG_PB_ADDR:  b = s.pb_addr;
      ira_pkg::REG_PB_DATA:  b = s.pb_data;
      default:               b = ira_pkg::RST_BYTE;
    endcase
    rd_mux = {24'h00_0000, b};
  endfunction : rd_mux

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  ira_pkg::ira_state_t state_reg;
  ira_pkg::ira_state_t state_next;

  logic [6:0] idx;
  logic       take;
  logic [7:0] wbyte;

  assign idx   = WB_ADR_I[8:2];
  assign take  = WB_CYC_I && WB_STB_I && !state_reg.ack;
  assign wbyte = WB_DAT_I[7:0];

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    state_next        = state_reg;
    state_next.ack    = 1'b0;
    state_next.ana_we = 1'b0;
    state_next.ana_re = 1'b0;

    // The counter restarts on every valid reverse channel event, so the
    // indication only falls after a whole quiet timeout. A shorter timeout
    // chosen mid-count takes effect at once through the compare.
    if (RC_VALID_I)
    begin
      state_next.ld_up  = 1'b1;
      state_next.ld_cnt = '0;
    end
    else if (state_reg.ld_up)
    begin
      if (state_reg.ld_cnt >=
          ira_pkg::LD_CNT_W'(ld_limit(state_reg.ld_timer) - 1'b1))
      begin
        state_next.ld_up  = 1'b0;
        state_next.ld_cnt = '0;
      end
      else
      begin
        state_next.ld_cnt =
          ira_pkg::LD_CNT_W'(state_reg.ld_cnt + 1'b1);
      end
    end

    // The offset steps one cycle after the write strobe, so the target
    // still sees the old offset while the strobe is high.
    if (state_reg.ana_we && state_reg.ana_inc)
    begin
      state_next.ana_off = incr8(state_reg.ana_off);
    end

    if (state_reg.pb_start && PB_ACK_I)
    begin
      state_next.pb_data  = PB_RDATA_I;
      state_next.pb_start = 1'b0;
      if (state_reg.pb_inc)
      begin
        state_next.pb_addr = incr8(state_reg.pb_addr);
      end
    end

    case (state_reg.wst)
      ira_pkg::ST_IDLE:
      begin
        if (take)
        begin
          state_next.dat = rd_mux(state_reg, idx);
          if (WB_WE_I && WB_SEL_I[0])
          begin
            // A software write lands after the hardware updates above, so
            // a start written in the completion cycle launches a new read.
            case (idx)
              ira_pkg::REG_LINK_DET:
                state_next.ld_timer =
                  wbyte[ira_pkg::LD_TIMER_LSB +: 2];
              ira_pkg::REG_ANA_CTRL:
              begin
                state_next.ana_sel = wbyte[ira_pkg::ANA_SEL_LSB +: 3];
                state_next.ana_inc = wbyte[ira_pkg::ANA_INC_BIT];
                state_next.ana_rd  = wbyte[ira_pkg::ANA_RD_BIT];
              end
              ira_pkg::REG_ANA_OFF:
                state_next.ana_off = wbyte;
              ira_pkg::REG_ANA_DATA:
              begin
                state_next.ana_data = wbyte;
                if (ana_target_ok(state_reg.ana_sel) && !state_reg.ana_rd)
                begin
                  state_next.ana_we = 1'b1;
                end
              end
              ira_pkg::REG_PB_CTRL:
              begin
                state_next.pb_sel = wbyte[ira_pkg::PB_SEL_LSB +: 2];
                state_next.pb_inc = wbyte[ira_pkg::PB_INC_BIT];
                state_next.pb_en  = wbyte[ira_pkg::PB_EN_BIT];
                // Only the high select bit marks a valid target; reserved
                // targets and a disabled interface never start a read.
                if (!wbyte[ira_pkg::PB_EN_BIT])
                begin
                  state_next.pb_start = 1'b0;
                end
                else if (wbyte[ira_pkg::PB_START_BIT] &&
                         wbyte[ira_pkg::PB_SEL_LSB + ira_pkg::PB_SEL_HI_BIT])
                begin
                  state_next.pb_start = 1'b1;
                end
              end
              ira_pkg::REG_PB_ADDR:
                state_next.pb_addr = wbyte;
              ira_pkg::REG_PB_DATA:
              begin
                state_next.pb_data = wbyte;
                // Targets are read-only; the write completes locally.
                if (state_reg.pb_en && state_reg.pb_inc)
                begin
                  state_next.pb_addr = incr8(state_reg.pb_addr);
                end
              end
              default:
                state_next.dat = ira_pkg::RD_ZERO;
            endcase
            state_next.ack = 1'b1;
          end
          else if (!WB_WE_I && idx == ira_pkg::REG_ANA_DATA &&
                   state_reg.ana_rd && ana_target_ok(state_reg.ana_sel))
          begin
            state_next.ana_re = 1'b1;
            state_next.wst    = ira_pkg::ST_ANA_RD1;
          end
          else
          begin
            state_next.ack = 1'b1;
          end
        end
      end
      ira_pkg::ST_ANA_RD1:
        state_next.wst = ira_pkg::ST_ANA_RD2;
      ira_pkg::ST_ANA_RD2:
      begin
        // The target answers one cycle after its read strobe.
        state_next.ana_data = ANA_RDATA_I;
        state_next.dat      = {24'h00_0000, ANA_RDATA_I};
        state_next.ack      = 1'b1;
        state_next.wst      = ira_pkg::ST_IDLE;
        if (state_reg.ana_inc)
        begin
          state_next.ana_off = incr8(state_reg.ana_off);
        end
      end
      default:
        state_next.wst = ira_pkg::ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign WB_DAT_O      = state_reg.dat;
  assign WB_ACK_O      = state_reg.ack;
  assign LINK_DETECT_O = state_reg.ld_up;
  assign ANA_SEL_O     = state_reg.ana_sel;
  assign ANA_ADDR_O    = state_reg.ana_off;
  assign ANA_WDATA_O   = state_reg.ana_data;
  assign ANA_WE_O      = state_reg.ana_we;
  assign ANA_RE_O      = state_reg.ana_re;
  assign PB_REQ_O      = state_reg.pb_start;
  assign PB_SEL_O      = state_reg.pb_sel;
  assign PB_ADDR_O     = state_reg.pb_addr;

endmodule : ira_top

// ### hw/ira_pkg.sv
// Constants, types and register map of the indirect register access block.
package ira_pkg;

  // ---------------------------------------------------------------------
  // Clock and link detect timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned LD_TO_00_US   = 325;
  localparam int unsigned LD_TO_01_US   = 162;
  localparam int unsigned LD_TO_10_US   = 650;
  // The longest timeout is 1.3 ms, held here in microseconds.
  localparam int unsigned LD_TO_11_US   = 1300;
  localparam int unsigned LD_CNT_W      = 14;

  // ---------------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam int unsigned IDX_W         = 7;
  localparam logic [6:0]  REG_LINK_DET  = 7'h26;
  localparam logic [6:0]  REG_ANA_CTRL  = 7'h40;
  localparam logic [6:0]  REG_ANA_OFF   = 7'h41;
  localparam logic [6:0]  REG_ANA_DATA  = 7'h42;
  localparam logic [6:0]  REG_PB_CTRL   = 7'h48;
  localparam logic [6:0]  REG_PB_ADDR   = 7'h49;
  localparam logic [6:0]  REG_PB_DATA   = 7'h4B;

  // ---------------------------------------------------------------------
  // Field positions, codes and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned LD_TIMER_LSB  = 0;
  localparam int unsigned ANA_SEL_LSB   = 2;
  localparam int unsigned ANA_INC_BIT   = 1;
  localparam int unsigned ANA_RD_BIT    = 0;
  localparam int unsigned PB_SEL_LSB    = 3;
  localparam int unsigned PB_INC_BIT    = 2;
  localparam int unsigned PB_START_BIT  = 1;
  localparam int unsigned PB_EN_BIT     = 0;
  localparam int unsigned PB_SEL_HI_BIT = 1;

  localparam logic [2:0]  ANA_SEL_OFF   = 3'h0;
  localparam logic [2:0]  ANA_SEL_VRX   = 3'h4;
  localparam logic [2:0]  ANA_SEL_STX   = 3'h5;
  localparam logic [1:0]  PB_SEL_CFG    = 2'h2;
  localparam logic [1:0]  PB_SEL_DIE_ID = 2'h3;

  localparam logic [7:0]  STEP8         = 8'h01;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ANA_RD1,
    ST_ANA_RD2
  } ira_wb_st_t;

  typedef struct packed {
    ira_wb_st_t            wst;
    logic                  ack;
    logic [31:0]           dat;
    logic [1:0]            ld_timer;
    logic [LD_CNT_W-1:0]   ld_cnt;
    logic                  ld_up;
    logic [2:0]            ana_sel;
    logic                  ana_inc;
    logic                  ana_rd;
    logic [7:0]            ana_off;
    logic [7:0]            ana_data;
    logic                  ana_we;
    logic                  ana_re;
    logic [1:0]            pb_sel;
    logic                  pb_inc;
    logic                  pb_start;
    logic                  pb_en;
    logic [7:0]            pb_addr;
    logic [7:0]            pb_data;
  } ira_state_t;

endpackage : ira_pkg

// ### dv/ira_checker.sv
// Port-level assertions for the indirect register access block.
`timescale 1ns/1ps
module ira_checker (
  input wire logic        SYS_CLK_I,     // System clock.
  input wire logic        RST_N_I,       // Reset, active low.
  input wire logic        WB_CYC_I,      // Bus cycle.
  input wire logic        WB_STB_I,      // Bus strobe.
  input wire logic [31:0] WB_DAT_O,      // Read data.
  input wire logic        WB_ACK_O,      // Acknowledge.
  input wire logic        RC_VALID_I,    // Reverse traffic seen.
  input wire logic        LINK_DETECT_O, // Link detected.
  input wire logic [2:0]  ANA_SEL_O,     // Analog target.
  input wire logic        ANA_WE_O,      // Analog write strobe.
  input wire logic        ANA_RE_O,      // Analog read strobe.
  input wire logic        PB_REQ_O,      // Peripheral request.
  input wire logic [1:0]  PB_SEL_O,      // Peripheral target.
  input wire logic [7:0]  PB_ADDR_O,     // Peripheral address.
  input wire logic        PB_ACK_I       // Peripheral done.
);
  wire logic bus_req = WB_CYC_I && WB_STB_I;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  property p_ack; WB_ACK_O |=> !WB_ACK_O; endproperty
  property p_dat; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000; endproperty
  property p_awe; ANA_WE_O |-> WB_ACK_O && ANA_SEL_O inside {3'h4, 3'h5};
  endproperty
  property p_are; ANA_RE_O |-> ANA_SEL_O inside {3'h4, 3'h5}; endproperty
  // A fetched analog read is answered two cycles after the strobe.
  property p_rlat; ANA_RE_O |=> !WB_ACK_O ##1 WB_ACK_O; endproperty
  property p_hold; PB_REQ_O && !PB_ACK_I |=> PB_REQ_O || WB_ACK_O;
  endproperty
  property p_done; PB_REQ_O && PB_ACK_I && !bus_req |=> !PB_REQ_O;
  endproperty
  property p_psel; PB_REQ_O |-> PB_SEL_O[1]; endproperty
  property p_padr; PB_REQ_O && !PB_ACK_I && !bus_req |=> $stable(PB_ADDR_O);
  endproperty
  property p_link; RC_VALID_I |=> LINK_DETECT_O; endproperty
  a_ack: assert property (p_ack)
    else $error("ack longer than one cycle");
  a_dat: assert property (p_dat)
    else $error("upper read bits set");
  a_awe: assert property (p_awe)
    else $error("bad analog write");
  a_are: assert property (p_are)
    else $error("bad analog read");
  a_rlat: assert property (p_rlat)
    else $error("read answer late");
  a_hold: assert property (p_hold)
    else $error("request dropped");
  a_done: assert property (p_done)
    else $error("request stuck");
  a_psel: assert property (p_psel)
    else $error("reserved target");
  a_padr: assert property (p_padr)
    else $error("address moved");
  a_link: assert property (p_link)
    else $error("link not raised");
  c_awe: cover property (ANA_WE_O);
  c_are: cover property (ANA_RE_O);
  c_pb: cover property (PB_REQ_O && PB_ACK_I);
endmodule : ira_checker

bind ira_top ira_checker u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .RC_VALID_I(RC_VALID_I), .LINK_DETECT_O(LINK_DETECT_O),
  .ANA_SEL_O(ANA_SEL_O), .ANA_WE_O(ANA_WE_O), .ANA_RE_O(ANA_RE_O),
  .PB_REQ_O(PB_REQ_O), .PB_SEL_O(PB_SEL_O), .PB_ADDR_O(PB_ADDR_O),
  .PB_ACK_I(PB_ACK_I)
);

// ### dv/testbench.sv
// Self-checking bench for the indirect register access block.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic [31:0] wdat = 32'h00000000, rdat;
  logic        ack, ld, awe, are, preq, pack = 1'b0, rc = 1'b0;
  logic [2:0]  asel;
  logic [1:0]  psel;
  logic [7:0]  aaddr, awd, paddr, d, ardat = 8'h00, prdat = 8'h00;
  logic [7:0]  wa = 8'h00, wd = 8'h00;
  logic [6:0]  regs [8] = '{7'h26, 7'h40, 7'h41, 7'h42, 7'h48, 7'h49,
                            7'h4B, 7'h10};
  int          lims [4] = '{20, 10, 40, 80};
  int          miscompares = 0, total_checks = 0, we_cnt = 0, pc = 0, n;

  ira_top #(.LD_CYC_00(20), .LD_CYC_01(10), .LD_CYC_10(40), .LD_CYC_11(80))
  u_dut (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .RC_VALID_I(rc), .LINK_DETECT_O(ld),
    .ANA_SEL_O(asel), .ANA_ADDR_O(aaddr), .ANA_WDATA_O(awd),
    .ANA_WE_O(awe), .ANA_RE_O(are), .ANA_RDATA_I(ardat), .PB_REQ_O(preq),
    .PB_SEL_O(psel), .PB_ADDR_O(paddr), .PB_RDATA_I(prdat),
    .PB_ACK_I(pack)
  );

  initial forever #50 clk = ~clk;

  // ---------------------------------------------------------------------
  // Far-side responders
  // ---------------------------------------------------------------------
  // Idle read lines toggle so a stale sample never matches by chance.
  always @(posedge clk)
  begin
    ardat <= are ? (8'hA0 ^ aaddr ^ {5'h00, asel}) : ~ardat;
    prdat <= preq ? (8'h50 ^ paddr ^ {psel, 6'h00}) : ~prdat;
    pc <= (preq && !pack) ? pc + 1 : 0;
    pack <= preq && !pack && pc == 2;
    if (awe)
    begin
      we_cnt <= we_cnt + 1;
      wa <= aaddr;
      wd <= awd;
    end
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h000000, v};
    // Ack is looked at on the rising edge; read data is taken at that
    // same edge and the request is released right after it.
    do
    begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1)
    begin
      miscompares++;
      finish_test();
    end
    d = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // Let the responders settle before the caller compares anything.
    @(negedge clk);
  endtask : bus

  task automatic rdc(input logic [6:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(d, e);
  endtask : rdc

  task automatic poll;
    int k;
    for (k = 0; k < 30; k++)
    begin
      bus(1'b0, 7'h48, 8'h00);
      if (d[1] === 1'b0)
        break;
    end
    if (k == 30)
    begin
      miscompares++;
      finish_test();
    end
  endtask : poll

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int j = 0; j < 8; j++)
      rdc(regs[j], 8'h00);
    $display("test reset values done");
    bus(1'b1, 7'h26, 8'hFF);
    rdc(7'h26, 8'h03);
    for (int t = 0; t < 4; t++)
    begin
      bus(1'b1, 7'h26, t[7:0]);
      @(posedge clk) rc <= 1'b1;
      @(posedge clk) rc <= 1'b0;
      @(negedge clk) chk(ld, 8'h01);
      for (n = 0; n < 200 && ld === 1'b1; n++)
        @(negedge clk);
      if (n == 200)
      begin
        miscompares++;
        finish_test();
      end
      chk(n >= lims[t] - 2 && n <= lims[t] + 2, 8'h01);
    end
    $display("test link detect done");
    bus(1'b1, 7'h40, 8'h12);
    bus(1'b1, 7'h41, 8'h10);
    bus(1'b1, 7'h42, 8'h5A);
    bus(1'b1, 7'h42, 8'hA5);
    chk(we_cnt, 8'h02);
    chk(wa, 8'h11);
    chk(wd, 8'hA5);
    rdc(7'h41, 8'h12);
    bus(1'b1, 7'h40, 8'h14);
    bus(1'b1, 7'h42, 8'h33);
    chk(wa, 8'h12);
    rdc(7'h41, 8'h12);
    bus(1'b1, 7'h40, 8'h13);
    rdc(7'h42, 8'hB6);
    rdc(7'h41, 8'h13);
    bus(1'b1, 7'h41, 8'h30);
    bus(1'b1, 7'h40, 8'h17);
    rdc(7'h42, 8'h95);
    bus(1'b1, 7'h40, 8'hFF);
    rdc(7'h40, 8'h1F);
    bus(1'b1, 7'h40, 8'h00);
    bus(1'b1, 7'h42, 8'h77);
    chk(we_cnt, 8'h03);
    rdc(7'h42, 8'h77);
    $display("test analog window done");
    bus(1'b1, 7'h49, 8'h20);
    bus(1'b1, 7'h48, 8'h17);
    poll();
    chk(d, 8'h15);
    rdc(7'h4B, 8'hF0);
    rdc(7'h49, 8'h21);
    bus(1'b1, 7'h48, 8'h1B);
    poll();
    rdc(7'h4B, 8'hB1);
    rdc(7'h49, 8'h21);
    bus(1'b1, 7'h48, 8'h03);
    rdc(7'h48, 8'h01);
    bus(1'b1, 7'h48, 8'h16);
    rdc(7'h48, 8'h14);
    // A data-low write with the interface enabled and autostep set steps the address too.
    bus(1'b1, 7'h48, 8'h05);
    bus(1'b1, 7'h4B, 8'h66);
    rdc(7'h49, 8'h22);
    rdc(7'h4B, 8'h66);
    $display("test peripheral window done");
    @(posedge clk) rc <= 1'b1;
    @(posedge clk) rc <= 1'b0;
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk) chk(ld, 8'h00);
    rdc(7'h49, 8'h00);
    rdc(7'h41, 8'h00);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : testbench
